// File: logic/ref_clock_switch_map.vh
`ifndef REF_CLOCK_SWITCH_MAP_VH
`define REF_CLOCK_SWITCH_MAP_VH

// Register byte offsets
`define RCS_OFS_EVENT_STATUS 8'h00
`define RCS_OFS_EVENT_ENABLE 8'h04
`define RCS_OFS_EVENT_CLEAR 8'h08
`define RCS_OFS_LIVE_STATUS 8'h0c
`define RCS_OFS_CONTROL 8'h10

// Event bits (status, enable and clear share the layout)
`define RCS_EVT_REF0_LOST 0
`define RCS_EVT_REF1_LOST 1
`define RCS_EVT_REF_SWITCH 2
`define RCS_EVT_WIDTH 3

// Live status bits
`define RCS_LIVE_REF0_LOST 0
`define RCS_LIVE_REF1_LOST 1
`define RCS_LIVE_ACTIVE_REF 2
`define RCS_LIVE_AUTO_MODE 3

// Control bits
`define RCS_CTL_AUTO_ALLOW 0

// Reset values
`define RCS_RST_EVENT_ENABLE 3'h0
`define RCS_RST_CONTROL 1'h1

// AXI responses
`define RCS_RESP_OKAY 2'h0
`define RCS_RESP_SLVERR 2'h2

`endif

// File: logic/redundant_ref_clock_switch.v
// How it works
// (R1) Exactly one of the two reference enables is high at any time, never both.
// (R2) Reference 0 is the primary and the reset choice; reference 1 is the secondary.
// (R3) The active reference indicator is low for reference 0 and high for reference 1.
// (R4) An input with no level change over one whole feedback clock period is failed.
// (R5) Each input has its own loss flag, driven high on failure.
// (R6) Both inputs are watched all the time and each flag clears when toggling resumes.
// (R7) With the auto select low the manual select pin alone picks the reference.
// (R8) In manual mode a change on the manual select pin moves the reference and indicator.
// (R9) An undriven auto select input reads high, enabling automatic failover.
// (R10) In automatic mode a failed primary with a healthy secondary switches to the secondary.
// (R11) After an automatic switch the indicator shows the secondary.
// (R12) In automatic mode the reference returns to the primary once its loss flag drops.
// (R13) Board logic should start in manual mode on reference 0 and then raise auto select.
// (R14) With auto select floating at start the device comes up in automatic mode.
// (R15) In automatic mode with both inputs failed the selection and indicator stay put.
`timescale 1ns/1ns
`include "ref_clock_switch_map.vh"

module redundant_ref_clock_switch #(
  parameter ADDR_WIDTH = 8
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Reference and feedback clocks, sampled
  input wire primaryRefInput,
  input wire secondaryRefInput,
  input wire feedbackClkIn,
  // Selection pins
  input wire autoSelIn,
  input wire autoSelDriven,
  input wire manualRefSelect,
  // Reference routing and indication
  output wire refEnable0,
  output wire refEnable1,
  output wire activeRefIndicator,
  output wire ref0LostFlag,
  output wire ref1LostFlag,
  // Interrupt
  output wire irq,
  // AXI4-Lite write address
  input wire [ADDR_WIDTH-1:0] awaddr,
  input wire awvalid,
  output wire awready,
  // AXI4-Lite write data
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  // AXI4-Lite write response
  output wire [1:0] bresp,
  output wire bvalid,
  input wire bready,
  // AXI4-Lite read address
  input wire [ADDR_WIDTH-1:0] araddr,
  input wire arvalid,
  output wire arready,
  // AXI4-Lite read data
  output wire [31:0] rdata,
  output wire [1:0] rresp,
  output wire rvalid,
  input wire rready
);

  // Decode of mapped offsets
  function isMapped;
    input [ADDR_WIDTH-1:0] addr;
    begin
      isMapped = (addr[7:0] == `RCS_OFS_EVENT_STATUS) ||
                 (addr[7:0] == `RCS_OFS_EVENT_ENABLE) ||
                 (addr[7:0] == `RCS_OFS_EVENT_CLEAR) ||
                 (addr[7:0] == `RCS_OFS_LIVE_STATUS) ||
                 (addr[7:0] == `RCS_OFS_CONTROL);
    end
  endfunction

  // Input history
  reg ref0Prev_ff;
  reg ref1Prev_ff;
  reg fbPrev_ff;
  reg fbStarted_ff;
  reg ref0Seen_ff;
  reg ref1Seen_ff;

  // Monitor and selection state
  reg ref0Lost_ff;
  reg ref1Lost_ff;
  reg refSel_ff;
  reg refEnable0_ff;
  reg refEnable1_ff;
  reg indicator_ff;
  reg autoMode_ff;

  // Register file
  reg [`RCS_EVT_WIDTH-1:0] evtStatus_ff;
  reg [`RCS_EVT_WIDTH-1:0] evtEnable_ff;
  reg autoAllow_ff;
  reg irq_ff;

  // Bus state
  reg awready_ff;
  reg wready_ff;
  reg [ADDR_WIDTH-1:0] awAddr_ff;
  reg [31:0] wData_ff;
  reg [3:0] wStrb_ff;
  reg bvalid_ff;
  reg [1:0] bresp_ff;
  reg arready_ff;
  reg rvalid_ff;
  reg [31:0] rdata_ff;
  reg [1:0] rresp_ff;

  wire fbRise;
  wire ref0Toggle;
  wire ref1Toggle;
  wire autoSelLevel;
  wire autoActive;
  wire doWrite;
  wire doRead;
  reg nxt_refSel;
  reg [`RCS_EVT_WIDTH-1:0] nxt_evtSet;
  reg [`RCS_EVT_WIDTH-1:0] nxt_evtClear;
  reg [31:0] nxt_rdata;

  assign fbRise = feedbackClkIn & ~fbPrev_ff;
  assign ref0Toggle = primaryRefInput ^ ref0Prev_ff;
  assign ref1Toggle = secondaryRefInput ^ ref1Prev_ff;
  // Undriven auto select is pulled high [R9] [R14]
  assign autoSelLevel = autoSelDriven ? autoSelIn : 1'b1;
  assign autoActive = autoSelLevel & autoAllow_ff;

  // Stuck-at monitor on each input, one feedback period per window
  always @(posedge clk) begin
    // History runs through reset, so release shows no false edge
    ref0Prev_ff <= primaryRefInput;
    ref1Prev_ff <= secondaryRefInput;
    fbPrev_ff <= feedbackClkIn;
    if (rst) begin
      fbStarted_ff <= 1'b0;
      ref0Seen_ff <= 1'b0;
      ref1Seen_ff <= 1'b0;
      ref0Lost_ff <= 1'b0;
      ref1Lost_ff <= 1'b0;
    end else begin
      if (fbRise) begin
        fbStarted_ff <= 1'b1;
        ref0Seen_ff <= 1'b0;
        ref1Seen_ff <= 1'b0;
        if (fbStarted_ff) begin
          ref0Lost_ff <= ~(ref0Seen_ff | ref0Toggle); // [R4] [R5] [R6]
          ref1Lost_ff <= ~(ref1Seen_ff | ref1Toggle); // [R4] [R5] [R6]
        end
      end else begin
        if (ref0Toggle) begin
          ref0Seen_ff <= 1'b1;
        end
        if (ref1Toggle) begin
          ref1Seen_ff <= 1'b1;
        end
      end
    end
  end

  // Reference selection
  always @* begin
    nxt_refSel = refSel_ff;
    if (!autoActive) begin
      nxt_refSel = manualRefSelect; // [R7] [R8]
    end else if (!refSel_ff) begin
      if (ref0Lost_ff && !ref1Lost_ff) begin
        nxt_refSel = 1'b1; // [R10]
      end else begin
        nxt_refSel = 1'b0; // [R15]
      end
    end else if (!ref0Lost_ff) begin
      nxt_refSel = 1'b0; // [R12]
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      refSel_ff <= 1'b0; // [R2]
      refEnable0_ff <= 1'b1;
      refEnable1_ff <= 1'b0;
      indicator_ff <= 1'b0;
      autoMode_ff <= 1'b0;
    end else begin
      refSel_ff <= nxt_refSel;
      refEnable0_ff <= ~nxt_refSel; // [R1]
      refEnable1_ff <= nxt_refSel; // [R1]
      indicator_ff <= nxt_refSel; // [R3] [R8] [R11]
      autoMode_ff <= autoActive;
    end
  end

  // Event capture
  always @* begin
    nxt_evtSet = {`RCS_EVT_WIDTH{1'b0}};
    nxt_evtSet[`RCS_EVT_REF0_LOST] = fbRise & fbStarted_ff & ~ref0Lost_ff &
                                     ~(ref0Seen_ff | ref0Toggle);
    nxt_evtSet[`RCS_EVT_REF1_LOST] = fbRise & fbStarted_ff & ~ref1Lost_ff &
                                     ~(ref1Seen_ff | ref1Toggle);
    nxt_evtSet[`RCS_EVT_REF_SWITCH] = nxt_refSel ^ refSel_ff;
    nxt_evtClear = {`RCS_EVT_WIDTH{1'b0}};
    if (doWrite && awAddr_ff[7:0] == `RCS_OFS_EVENT_CLEAR && wStrb_ff[0]) begin
      nxt_evtClear = wData_ff[`RCS_EVT_WIDTH-1:0];
    end
  end

  // Register file and interrupt
  always @(posedge clk) begin
    if (rst) begin
      evtStatus_ff <= {`RCS_EVT_WIDTH{1'b0}};
      evtEnable_ff <= `RCS_RST_EVENT_ENABLE;
      autoAllow_ff <= `RCS_RST_CONTROL;
      irq_ff <= 1'b0;
    end else begin
      evtStatus_ff <= (evtStatus_ff & ~nxt_evtClear) | nxt_evtSet;
      irq_ff <= |(((evtStatus_ff & ~nxt_evtClear) | nxt_evtSet) & evtEnable_ff);
      if (doWrite && awAddr_ff[7:0] == `RCS_OFS_EVENT_ENABLE && wStrb_ff[0]) begin
        evtEnable_ff <= wData_ff[`RCS_EVT_WIDTH-1:0];
      end
      if (doWrite && awAddr_ff[7:0] == `RCS_OFS_CONTROL && wStrb_ff[0]) begin
        autoAllow_ff <= wData_ff[`RCS_CTL_AUTO_ALLOW];
      end
    end
  end

  // Write channel: address and data in either order
  assign doWrite = ~awready_ff & ~wready_ff & ~bvalid_ff;

  always @(posedge clk) begin
    if (rst) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      awAddr_ff <= {ADDR_WIDTH{1'b0}};
      wData_ff <= 32'h0;
      wStrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `RCS_RESP_OKAY;
    end else begin
      if (awvalid && awready_ff) begin
        awready_ff <= 1'b0;
        awAddr_ff <= awaddr;
      end
      if (wvalid && wready_ff) begin
        wready_ff <= 1'b0;
        wData_ff <= wdata;
        wStrb_ff <= wstrb;
      end
      if (doWrite) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= isMapped(awAddr_ff) ? `RCS_RESP_OKAY : `RCS_RESP_SLVERR;
      end else if (bvalid_ff && bready) begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
    end
  end

  // Read channel
  assign doRead = arvalid & arready_ff;

  always @* begin
    nxt_rdata = 32'h0;
    case (araddr[7:0])
      `RCS_OFS_EVENT_STATUS: begin
        nxt_rdata[`RCS_EVT_WIDTH-1:0] = evtStatus_ff;
      end
      `RCS_OFS_EVENT_ENABLE: begin
        nxt_rdata[`RCS_EVT_WIDTH-1:0] = evtEnable_ff;
      end
      `RCS_OFS_LIVE_STATUS: begin
        nxt_rdata[`RCS_LIVE_REF0_LOST] = ref0Lost_ff;
        nxt_rdata[`RCS_LIVE_REF1_LOST] = ref1Lost_ff;
        nxt_rdata[`RCS_LIVE_ACTIVE_REF] = indicator_ff;
        nxt_rdata[`RCS_LIVE_AUTO_MODE] = autoMode_ff;
      end
      `RCS_OFS_CONTROL: begin
        nxt_rdata[`RCS_CTL_AUTO_ALLOW] = autoAllow_ff;
      end
      default: begin
        nxt_rdata = 32'h0;
      end
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= `RCS_RESP_OKAY;
    end else begin
      if (doRead) begin
        arready_ff <= 1'b0;
        rvalid_ff <= 1'b1;
        rdata_ff <= nxt_rdata;
        rresp_ff <= isMapped(araddr) ? `RCS_RESP_OKAY : `RCS_RESP_SLVERR;
      end else if (rvalid_ff) begin
        if (rready) begin
          rvalid_ff <= 1'b0;
          arready_ff <= 1'b1;
        end
      end else begin
        arready_ff <= 1'b1;
      end
    end
  end

  // Outputs
  assign refEnable0 = refEnable0_ff;
  assign refEnable1 = refEnable1_ff;
  assign activeRefIndicator = indicator_ff;
  assign ref0LostFlag = ref0Lost_ff;
  assign ref1LostFlag = ref1Lost_ff;
  assign irq = irq_ff;
  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;

endmodule

// File: verif/ref_source_model.sv
`timescale 1ns/1ns
module ref_source_model (
  // Clock
  input wire clk,
  // Fault controls
  input wire stuck0,
  input wire stuck1,
  // Sampled source levels
  output reg primaryRefInput = 1'h0,
  output reg secondaryRefInput = 1'h0,
  output reg feedbackClkIn = 1'h0
);
  reg [1:0] phase = 2'h0;

  // Feedback period is 8 clk; a stuck source simply stops toggling
  always @(posedge clk) begin
    phase <= phase + 2'h1;
    if (phase == 2'h3) feedbackClkIn <= ~feedbackClkIn;
    if (!stuck0) primaryRefInput <= ~primaryRefInput;
    if (!stuck1) secondaryRefInput <= ~secondaryRefInput;
  end
endmodule

// File: verif/redundant_ref_clock_switch_props.sv
`timescale 1ns/1ns
module redundant_ref_clock_switch_props (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Sources and pins
  input wire primaryRefInput,
  input wire secondaryRefInput,
  input wire feedbackClkIn,
  input wire autoSelIn,
  input wire autoSelDriven,
  input wire manualRefSelect,
  // Selection and flags
  input wire refEnable0,
  input wire refEnable1,
  input wire activeRefIndicator,
  input wire ref0LostFlag,
  input wire ref1LostFlag
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire autoOn = !autoSelDriven || autoSelIn;
  wire manOn = autoSelDriven && !autoSelIn;
  reg seenRise_ff = 1'h0;

  always @(posedge clk) begin
    if (rst) seenRise_ff <= 1'h0;
    else if ($rose(feedbackClkIn)) seenRise_ff <= 1'h1;
  end

  a_single_ref: assert property (refEnable0 != refEnable1)
    else $error("reference enables not exclusive");
  a_ind_follows: assert property (activeRefIndicator == refEnable1)
    else $error("indicator differs from enable");
  a_manual_pick: assert property (
    manOn |=> activeRefIndicator == $past(manualRefSelect))
    else $error("manual select not followed");
  a_loss_set: assert property (
    seenRise_ff && $rose(feedbackClkIn) && $stable(primaryRefInput)
    ##1 ($stable(primaryRefInput) && !$rose(feedbackClkIn)) [*7]
    ##1 ($stable(primaryRefInput) && $rose(feedbackClkIn)) |=> ref0LostFlag)
    else $error("stuck primary not flagged");
  a_loss_clear: assert property (
    $changed(secondaryRefInput) [*8] ##0 $rose(feedbackClkIn) |=> !ref1LostFlag)
    else $error("toggling secondary flagged");
  a_auto_fail: assert property (
    autoOn && !activeRefIndicator && ref0LostFlag && !ref1LostFlag |=> activeRefIndicator)
    else $error("no failover to secondary");
  a_auto_back: assert property (
    autoOn && activeRefIndicator && !ref0LostFlag |=> !activeRefIndicator)
    else $error("no return to primary");
  a_both_hold: assert property (
    autoOn && ref0LostFlag && ref1LostFlag |=> $stable(activeRefIndicator))
    else $error("selection moved with both lost");
endmodule

bind redundant_ref_clock_switch redundant_ref_clock_switch_props props_u (.clk(clk),
  .rst(rst), .primaryRefInput(primaryRefInput), .secondaryRefInput(secondaryRefInput),
  .feedbackClkIn(feedbackClkIn), .autoSelIn(autoSelIn), .autoSelDriven(autoSelDriven),
  .manualRefSelect(manualRefSelect), .refEnable0(refEnable0), .refEnable1(refEnable1),
  .activeRefIndicator(activeRefIndicator), .ref0LostFlag(ref0LostFlag),
  .ref1LostFlag(ref1LostFlag));

// File: verif/tb_redundant_ref_clock_switch.sv
`timescale 1ns/1ns
`include "ref_clock_switch_map.vh"
module tb_redundant_ref_clock_switch;
  reg clk = 1'h0, rst = 1'h1, stuck0 = 1'h0, stuck1 = 1'h0;
  reg autoSelIn = 1'h0, autoSelDriven = 1'h1, manualRefSelect = 1'h0;
  reg [7:0] awaddr = 8'h00, araddr = 8'h00;
  reg [31:0] wdata = 32'h0, rdv;
  reg [3:0] wstrb = 4'hf;
  reg [1:0] rsp;
  reg awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  wire primaryRefInput, secondaryRefInput, feedbackClkIn, refEnable0, refEnable1;
  wire activeRefIndicator, ref0LostFlag, ref1LostFlag, irq;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  integer mismatches = 0, samples_checked = 0, cycles = 0;

  always #4 clk = ~clk;

  ref_source_model src_u (.clk, .stuck0, .stuck1, .primaryRefInput, .secondaryRefInput,
    .feedbackClkIn);
  redundant_ref_clock_switch dut_u (.clk, .rst, .primaryRefInput, .secondaryRefInput,
    .feedbackClkIn, .autoSelIn, .autoSelDriven, .manualRefSelect, .refEnable0, .refEnable1,
    .activeRefIndicator, .ref0LostFlag, .ref1LostFlag, .irq, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready);

  task summarize;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches = mismatches + 1;
      summarize;
    end
  end

  task chk(input string what, input [31:0] exp, input [31:0] got);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One register access; waits for the response, no fixed latency assumed
  task acc(input bit w, input [7:0] a, input [31:0] d);
    @(posedge clk);
    if (w) begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
    end else begin
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
    end
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (arready) arvalid <= 1'h0;
    end while (!(w ? bvalid : rvalid));
    bready <= 1'h0;
    rready <= 1'h0;
    rdv = rdata;
    rsp = w ? bresp : rresp;
  endtask

  task t_reset;
    chk("enable0", 1, refEnable0);
    chk("indicator", 0, activeRefIndicator);
    acc(0, `RCS_OFS_EVENT_ENABLE, 0);
    chk("enable reg", 0, rdv);
    acc(0, `RCS_OFS_CONTROL, 0);
    chk("control reg", 1, rdv[0]);
    acc(0, 8'h40, 0);
    chk("unmapped resp", `RCS_RESP_SLVERR, rsp);
    acc(1, 8'h40, 0);
    chk("unmapped wresp", `RCS_RESP_SLVERR, rsp);
    $display("test reset done");
  endtask

  task t_manual;
    manualRefSelect <= 1'h1;
    stuck1 <= 1'h1;
    repeat (30) @(posedge clk);
    chk("lost1", 1, ref1LostFlag);
    chk("indicator", 1, activeRefIndicator);
    chk("enable1", 1, refEnable1);
    acc(0, `RCS_OFS_EVENT_STATUS, 0);
    chk("status", (1 << `RCS_EVT_REF1_LOST) | (1 << `RCS_EVT_REF_SWITCH), rdv);
    manualRefSelect <= 1'h0;
    stuck1 <= 1'h0;
    repeat (30) @(posedge clk);
    chk("indicator", 0, activeRefIndicator);
    chk("lost1", 0, ref1LostFlag);
    $display("test manual done");
  endtask

  task t_irq;
    acc(1, `RCS_OFS_EVENT_CLEAR, 7);
    chk("clear wresp", `RCS_RESP_OKAY, rsp);
    acc(1, `RCS_OFS_EVENT_ENABLE, 1);
    chk("irq idle", 0, irq);
    stuck0 <= 1'h1;
    repeat (30) @(posedge clk);
    chk("lost0", 1, ref0LostFlag);
    chk("indicator", 0, activeRefIndicator);
    chk("irq", 1, irq);
    acc(0, `RCS_OFS_EVENT_STATUS, 0);
    chk("status", 1, rdv[0]);
    acc(1, `RCS_OFS_EVENT_ENABLE, 0);
    repeat (2) @(posedge clk);
    chk("irq masked", 0, irq);
    stuck0 <= 1'h0;
    repeat (30) @(posedge clk);
    chk("lost0", 0, ref0LostFlag);
    acc(1, `RCS_OFS_EVENT_ENABLE, 1);
    repeat (2) @(posedge clk);
    chk("irq sticky", 1, irq);
    acc(1, `RCS_OFS_EVENT_CLEAR, 1);
    repeat (2) @(posedge clk);
    chk("irq cleared", 0, irq);
    $display("test interrupt done");
  endtask

  task t_auto;
    autoSelDriven <= 1'h0;
    acc(1, `RCS_OFS_CONTROL, 1);
    stuck0 <= 1'h1;
    repeat (30) @(posedge clk);
    chk("indicator", 1, activeRefIndicator);
    chk("enable0", 0, refEnable0);
    acc(0, `RCS_OFS_LIVE_STATUS, 0);
    chk("live", (1 << `RCS_LIVE_REF0_LOST) | (1 << `RCS_LIVE_ACTIVE_REF) |
      (1 << `RCS_LIVE_AUTO_MODE), rdv);
    stuck0 <= 1'h0;
    repeat (30) @(posedge clk);
    chk("indicator", 0, activeRefIndicator);
    stuck0 <= 1'h1;
    stuck1 <= 1'h1;
    repeat (30) @(posedge clk);
    chk("indicator", 0, activeRefIndicator);
    $display("test auto done");
  endtask

  // Board starts in manual mode on the primary, as recommended
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    repeat (2) @(posedge clk);
    t_reset;
    t_manual;
    t_irq;
    t_auto;
    summarize;
  end
endmodule
